// [sgc_pkg.sv]
// Purpose: Constants for the switchgear command gating and status block.
// Assumes: 200 MHz aclk; AXI4-Lite register access with 32-bit data.
// Notes: Times are in ms; cycle counts derive from the clock rate.
package sgc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned OPER_MS = 150;
  localparam int unsigned MIN_PULSE_MS = 1000;
  localparam int unsigned PULSE_MS = 1000;
  localparam int unsigned MAX_OPER_MS = 10000;
  localparam int unsigned MAX_INTER_MS = 10000;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned OPER_CYC = OPER_MS * CYC_PER_MS;
  localparam int unsigned MIN_PULSE_CYC = MIN_PULSE_MS * CYC_PER_MS;
  localparam int unsigned PULSE_CYC = PULSE_MS * CYC_PER_MS;
  localparam int unsigned MAX_OPER_CYC = MAX_OPER_MS * CYC_PER_MS;
  localparam int unsigned MAX_INTER_CYC = MAX_INTER_MS * CYC_PER_MS;
  // Status encoding.
  localparam logic [1:0] ST_INTER = 2'h0;
  localparam logic [1:0] ST_OFF = 2'h1;
  localparam logic [1:0] ST_ON = 2'h2;
  localparam logic [1:0] ST_BAD = 2'h3;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_OPCNT = 8'h10;
  localparam logic [7:0] REG_PULSE = 8'h14;
  localparam logic [7:0] REG_MAXOP = 8'h18;
  localparam logic [7:0] REG_MAXINT = 8'h1C;
  localparam logic [7:0] REG_CMD = 8'h20;
  // CTRL bits; CMD bits; interrupt bits.
  localparam int unsigned CTRL_LOCAL_EN = 0;
  localparam int unsigned CTRL_REMOTE_EN = 1;
  localparam int unsigned CTRL_CNT_CLR = 2;
  localparam int unsigned CMD_OPEN = 0;
  localparam int unsigned CMD_CLOSE = 1;
  localparam int unsigned IRQ_STATUS = 0;
  localparam int unsigned IRQ_OPER = 1;
  localparam int unsigned IRQ_TIMEOUT = 2;
  localparam int unsigned IRQ_REFUSED = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [sgc_status_if.sv]
`timescale 1ns/1ps
// Purpose: Carries the filtered position status between filter and core.
// Assumes: One clock domain.
// Notes: The filter drives, the core listens.
interface sgc_status_if;
  logic [1:0] status;
  logic changed;
  modport filt (output status, output changed);
  modport core (input status, input changed);
endinterface // sgc_status_if

// [sgc_pos_filter.sv]
`timescale 1ns/1ps
// Purpose: Encodes the two position contacts into a filtered status.
// Assumes: Contacts are synchronous to aclk.
// Notes: Only the intermediate code is delayed; the others pass at once.
module sgc_pos_filter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic closed_position_in,
  input wire logic open_position_in,
  input wire logic [31:0] inter_wait_cyc,
  sgc_status_if.filt st
);
  logic [1:0] raw;
  logic [31:0] wait_q;
  logic [1:0] status_q;

  // Raw code: closed in bit one, open in bit zero.
  assign raw = {closed_position_in, open_position_in};

  // Hold the last valid status for up to inter_wait_cyc cycles while both contacts drop, since a moving
  // switch passes through that state on every normal travel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q <= '0;
      status_q <= sgc_pkg::ST_INTER;
      st.changed <= 1'b0;
    end else begin
      st.changed <= 1'b0;
      if (raw != sgc_pkg::ST_INTER) begin
        wait_q <= '0;
        if (raw != status_q) begin
          status_q <= raw;
          st.changed <= 1'b1;
        end
      end else if (status_q != sgc_pkg::ST_INTER) begin
        if (wait_q + 32'h1 >= inter_wait_cyc) begin
          status_q <= sgc_pkg::ST_INTER;
          st.changed <= 1'b1;
          wait_q <= '0;
        end else begin
          wait_q <= wait_q + 32'h1;
        end
      end
    end
  end

  assign st.status = status_q;
endmodule // sgc_pos_filter

// [sgc_ctrl.sv]
`timescale 1ns/1ps
// Purpose: Gates open and close commands and reports switch position.
// Assumes: All discrete inputs are synchronous to aclk.
// Notes: Registers sit on an AXI4-Lite slave; one request at a time.
module sgc_ctrl #(
  parameter int unsigned OPER_CYC = sgc_pkg::OPER_CYC,
  parameter int unsigned MIN_PULSE_CYC = sgc_pkg::MIN_PULSE_CYC,
  parameter logic [31:0] PULSE_RST = 32'(sgc_pkg::PULSE_CYC),
  parameter logic [31:0] MAXOP_RST = 32'(sgc_pkg::MAX_OPER_CYC),
  parameter logic [31:0] MAXINT_RST = 32'(sgc_pkg::MAX_INTER_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic local_mode,
  input wire logic remote_mode,
  input wire logic local_open_req,
  input wire logic local_close_req,
  input wire logic open_permit,
  input wire logic close_permit,
  input wire logic sync_check_ok,
  input wire logic operation_block,
  input wire logic closed_position_in,
  input wire logic open_position_in,
  output logic open_cmd_pulse,
  output logic close_cmd_pulse,
  output logic oper_pulse,
  output logic closed_out,
  output logic opened_out,
  output logic [1:0] integer_position_status,
  output logic [1:0] remote_position_status,
  output logic status_event,
  output logic cmd_timeout,
  output logic irq
);
  typedef enum logic [1:0] {SGC_IDLE, SGC_PULSE, SGC_WAIT} sgc_state_e;

  sgc_state_e state_q;
  sgc_status_if st_if ();
  logic [1:0] ctrl_q;
  logic cnt_clr;
  logic [31:0] pulse_cyc_q;
  logic [31:0] maxop_cyc_q;
  logic [31:0] maxint_cyc_q;
  logic [31:0] opcnt_q;
  logic [sgc_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sgc_pkg::IRQ_W-1:0] irq_mask_q;
  logic [sgc_pkg::IRQ_W-1:0] irq_set;
  logic [sgc_pkg::IRQ_W-1:0] irq_clr;
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [31:0] wmask;
  logic remote_open_req;
  logic remote_close_req;
  logic want_open;
  logic want_close;
  logic go_open;
  logic go_close;
  logic dir_close_q;
  logic [31:0] pulse_t_q;
  logic [31:0] op_t_q;
  logic [31:0] oper_t_q;
  logic confirmed;

  sgc_pos_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .closed_position_in(closed_position_in),
    .open_position_in(open_position_in),
    .inter_wait_cyc(maxint_cyc_q),
    .st(st_if.filt)
  );

  // AXI write channel: address and data may arrive in either order.
  // Readies are flops so that no top output rides on a gate path.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sgc_pkg::RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > sgc_pkg::REG_CMD || awaddr_q[1:0] != 2'h0)
                       ? sgc_pkg::RESP_SLVERR : sgc_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_q && w_q && !s_axi_bvalid;

  // Byte-lane mask from the write strobes.
  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
    end
  endgenerate

  // Writable registers; counter clear and remote commands are pulses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 2'h3;
      pulse_cyc_q <= PULSE_RST;
      maxop_cyc_q <= MAXOP_RST;
      maxint_cyc_q <= MAXINT_RST;
      irq_mask_q <= '0;
    end else if (wr_fire) begin
      unique case (awaddr_q)
        sgc_pkg::REG_CTRL: ctrl_q <= (wdata_q[1:0] & wmask[1:0]) |
                                     (ctrl_q & ~wmask[1:0]);
        sgc_pkg::REG_IRQ_MASK: irq_mask_q <= wdata_q[sgc_pkg::IRQ_W-1:0];
        sgc_pkg::REG_PULSE: pulse_cyc_q <= (wdata_q & wmask) |
                                           (pulse_cyc_q & ~wmask);
        sgc_pkg::REG_MAXOP: maxop_cyc_q <= (wdata_q & wmask) |
                                           (maxop_cyc_q & ~wmask);
        sgc_pkg::REG_MAXINT: maxint_cyc_q <= (wdata_q & wmask) |
                                             (maxint_cyc_q & ~wmask);
        default: ;
      endcase
    end
  end

  assign cnt_clr = wr_fire && awaddr_q == sgc_pkg::REG_CTRL &&
                   wdata_q[sgc_pkg::CTRL_CNT_CLR];
  assign remote_open_req = wr_fire && awaddr_q == sgc_pkg::REG_CMD &&
                           wdata_q[sgc_pkg::CMD_OPEN];
  assign remote_close_req = wr_fire && awaddr_q == sgc_pkg::REG_CMD &&
                            wdata_q[sgc_pkg::CMD_CLOSE];
  assign irq_clr = (wr_fire && awaddr_q == sgc_pkg::REG_IRQ_STAT) ?
                   wdata_q[sgc_pkg::IRQ_W-1:0] : '0;

  // AXI read channel, one cycle after the address is taken.
  // Address ready is a flop that drops while read data waits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sgc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sgc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sgc_pkg::REG_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
        sgc_pkg::REG_STAT: s_axi_rdata <= {26'h0, state_q, cmd_timeout,
                                           operation_block,
                                           st_if.status};
        sgc_pkg::REG_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_q};
        sgc_pkg::REG_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_q};
        sgc_pkg::REG_OPCNT: s_axi_rdata <= opcnt_q;
        sgc_pkg::REG_PULSE: s_axi_rdata <= pulse_cyc_q;
        sgc_pkg::REG_MAXOP: s_axi_rdata <= maxop_cyc_q;
        sgc_pkg::REG_MAXINT: s_axi_rdata <= maxint_cyc_q;
        sgc_pkg::REG_CMD: s_axi_rdata <= 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= sgc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Gating: mode, permit and block must all hold together; close also needs sync check.
  assign want_open = (local_open_req && local_mode &&
                      ctrl_q[sgc_pkg::CTRL_LOCAL_EN]) ||
                     (remote_open_req && remote_mode &&
                      ctrl_q[sgc_pkg::CTRL_REMOTE_EN]);
  assign want_close = (local_close_req && local_mode &&
                       ctrl_q[sgc_pkg::CTRL_LOCAL_EN]) ||
                      (remote_close_req && remote_mode &&
                       ctrl_q[sgc_pkg::CTRL_REMOTE_EN]);
  // Inputs with no source are expected tied high outside.
  assign go_open = want_open && open_permit && !operation_block &&
                   state_q == SGC_IDLE;
  assign go_close = want_close && !want_open && close_permit &&
                    sync_check_ok && !operation_block &&
                    state_q == SGC_IDLE;
  assign confirmed = dir_close_q ? (st_if.status == sgc_pkg::ST_ON)
                                 : (st_if.status == sgc_pkg::ST_OFF);

  // Command sequencer: pulse, then wait for the position to confirm.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SGC_IDLE;
      dir_close_q <= 1'b0;
      pulse_t_q <= '0;
      op_t_q <= '0;
      open_cmd_pulse <= 1'b0;
      close_cmd_pulse <= 1'b0;
      cmd_timeout <= 1'b0;
    end else begin
      unique case (state_q)
        SGC_IDLE: begin
          pulse_t_q <= '0;
          op_t_q <= '0;
          if (go_open || go_close) begin
            state_q <= SGC_PULSE;
            dir_close_q <= go_close;
            open_cmd_pulse <= go_open;
            close_cmd_pulse <= go_close;
            cmd_timeout <= 1'b0;
          end
        end
        SGC_PULSE: begin
          pulse_t_q <= pulse_t_q + 32'h1;
          op_t_q <= op_t_q + 32'h1;
          // Early release only after the minimum width has passed.
          if (pulse_t_q + 32'h1 >= pulse_cyc_q ||
              (confirmed && pulse_t_q + 32'h1 >= MIN_PULSE_CYC)) begin
            open_cmd_pulse <= 1'b0;
            close_cmd_pulse <= 1'b0;
            state_q <= confirmed ? SGC_IDLE : SGC_WAIT;
          end
        end
        SGC_WAIT: begin
          op_t_q <= op_t_q + 32'h1;
          if (confirmed) begin
            state_q <= SGC_IDLE;
          end else if (op_t_q + 32'h1 >= maxop_cyc_q) begin
            cmd_timeout <= 1'b1;
            state_q <= SGC_IDLE;
          end
        end
        default: state_q <= SGC_IDLE;
      endcase
    end
  end

  // Operation pulse of fixed width and the operation counter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oper_t_q <= '0;
      oper_pulse <= 1'b0;
      opcnt_q <= '0;
    end else begin
      if (st_if.changed && (st_if.status == sgc_pkg::ST_ON ||
                            st_if.status == sgc_pkg::ST_OFF)) begin
        oper_pulse <= 1'b1;
        oper_t_q <= 32'(OPER_CYC) - 32'h1;
      end else if (oper_t_q != 32'h0) begin
        oper_t_q <= oper_t_q - 32'h1;
      end else begin
        oper_pulse <= 1'b0;
      end
      // A restart while high still counts once; a same-cycle clear and count leave one.
      if (st_if.changed && (st_if.status == sgc_pkg::ST_ON ||
                            st_if.status == sgc_pkg::ST_OFF)) begin
        opcnt_q <= cnt_clr ? 32'h1 : opcnt_q + 32'h1;
      end else if (cnt_clr) begin
        opcnt_q <= '0;
      end
    end
  end

  // Status outputs to display and remote paths, and position flags.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integer_position_status <= sgc_pkg::ST_INTER;
      remote_position_status <= sgc_pkg::ST_INTER;
      closed_out <= 1'b0;
      opened_out <= 1'b0;
      status_event <= 1'b0;
    end else begin
      integer_position_status <= st_if.status;
      remote_position_status <= st_if.status;
      closed_out <= st_if.status == sgc_pkg::ST_ON;
      opened_out <= st_if.status == sgc_pkg::ST_OFF;
      status_event <= st_if.changed;
    end
  end

  assign irq_set[sgc_pkg::IRQ_STATUS] = st_if.changed;
  assign irq_set[sgc_pkg::IRQ_OPER] = st_if.changed &&
                                      st_if.status[1] != st_if.status[0];
  assign irq_set[sgc_pkg::IRQ_TIMEOUT] = state_q == SGC_WAIT && !confirmed &&
                                         op_t_q + 32'h1 >= maxop_cyc_q;
  assign irq_set[sgc_pkg::IRQ_REFUSED] = (want_open || want_close) &&
                                         !go_open && !go_close;

  // Sticky interrupt status; a new event wins over a same-cycle clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end
endmodule // sgc_ctrl

// [sgc_ctrl_props.sv]
// Purpose: Timing checks on the command and status ports.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Run-length counters measure pulse widths and contact idle time.
`timescale 1ns/1ps
module sgc_ctrl_props #(
  parameter int unsigned OPER_CYC = 20,
  parameter int unsigned MIN_PULSE_CYC = 10,
  parameter logic [31:0] PULSE_RST = 32'h1E,
  parameter logic [31:0] MAXINT_RST = 32'h0F
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic local_mode,
  input wire logic remote_mode,
  input wire logic open_permit,
  input wire logic close_permit,
  input wire logic sync_check_ok,
  input wire logic operation_block,
  input wire logic closed_position_in,
  input wire logic open_position_in,
  input wire logic open_cmd_pulse,
  input wire logic close_cmd_pulse,
  input wire logic oper_pulse,
  input wire logic closed_out,
  input wire logic opened_out,
  input wire logic [1:0] integer_position_status,
  input wire logic [1:0] remote_position_status,
  input wire logic status_event
);
  logic [31:0] low_q, cmd_q, op_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Each run restarts when its condition drops, so widths are exact.
  always_ff @(posedge aclk) begin
    low_q <= (aresetn && !(closed_position_in || open_position_in)) ?
      low_q + 32'h1 : 32'h0;
    cmd_q <= (aresetn && (open_cmd_pulse || close_cmd_pulse)) ?
      cmd_q + 32'h1 : 32'h0;
    op_q <= (aresetn && oper_pulse) ? op_q + 32'h1 : 32'h0;
  end
  a_status_encode: assert property (
    (closed_position_in || open_position_in) |-> ##2
    integer_position_status == $past({closed_position_in, open_position_in}, 2))
    else $error("Status code does not match the contacts.");
  a_remote_copy: assert property (
    remote_position_status == integer_position_status)
    else $error("Remote status differs from local status.");
  a_filtered_out: assert property (
    closed_out == (integer_position_status == sgc_pkg::ST_ON) &&
    opened_out == (integer_position_status == sgc_pkg::ST_OFF))
    else $error("Closed or opened output disagrees with status.");
  a_event_change: assert property (
    $changed(integer_position_status) |-> ##[0:1] status_event)
    else $error("Status changed without an event.");
  a_inter_delay: assert property (
    $changed(integer_position_status) &&
    integer_position_status == sgc_pkg::ST_INTER |-> low_q >= MAXINT_RST)
    else $error("Intermediate reported before the wait ran out.");
  a_oper_width: assert property (
    $fell(oper_pulse) |-> op_q == OPER_CYC)
    else $error("Operation pulse has the wrong width.");
  a_cmd_width: assert property (
    $fell(open_cmd_pulse || close_cmd_pulse) |->
    cmd_q >= MIN_PULSE_CYC && cmd_q <= PULSE_RST)
    else $error("Command pulse width out of range.");
  a_open_gate: assert property (
    $rose(open_cmd_pulse) |-> $past(open_permit && !operation_block))
    else $error("Open issued without permit or while blocked.");
  a_close_gate: assert property (
    $rose(close_cmd_pulse) |->
    $past(close_permit && sync_check_ok && !operation_block))
    else $error("Close issued without its gating conditions.");
  a_mode_gate: assert property (
    $rose(open_cmd_pulse || close_cmd_pulse) |->
    $past(local_mode || remote_mode))
    else $error("Command issued with no mode active.");
  c_close_done: cover property ($fell(close_cmd_pulse));
  c_oper_done: cover property ($fell(oper_pulse));
  c_inter: cover property (integer_position_status == sgc_pkg::ST_INTER);
endmodule // sgc_ctrl_props
bind sgc_ctrl sgc_ctrl_props #(.OPER_CYC(OPER_CYC),
  .MIN_PULSE_CYC(MIN_PULSE_CYC), .PULSE_RST(PULSE_RST),
  .MAXINT_RST(MAXINT_RST)) i_sgc_ctrl_props (.aclk, .aresetn, .local_mode,
  .remote_mode, .open_permit, .close_permit, .sync_check_ok,
  .operation_block, .closed_position_in, .open_position_in, .open_cmd_pulse,
  .close_cmd_pulse, .oper_pulse, .closed_out, .opened_out,
  .integer_position_status, .remote_position_status, .status_event);

// [sgc_switch_model.sv]
// Purpose: Behavioural switch with travel time and contact faults.
// Assumes: Runs on the bench clock and reset.
// Notes: Starts open; a stuck switch ignores every command.
`timescale 1ns/1ps
module sgc_switch_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic open_cmd_pulse,
  input wire logic close_cmd_pulse,
  input wire logic stuck,
  input wire logic fault_both,
  input wire logic [7:0] travel_cyc,
  output logic closed_position_in,
  output logic open_position_in
);
  logic [1:0] cmd_q;
  logic [1:0] pos_q;
  logic [7:0] cnt_q;
  logic move_q;
  logic tgt_q;
  logic start;
  // A move starts on the leading edge only, so a long pulse cannot retrigger.
  assign start = !move_q && !stuck &&
    ((open_cmd_pulse && !cmd_q[0]) || (close_cmd_pulse && !cmd_q[1]));
  // Both contacts drop at once; the new one makes after the travel time.
  always_ff @(posedge aclk) begin
    cmd_q <= {close_cmd_pulse, open_cmd_pulse};
    if (!aresetn) begin
      pos_q <= 2'h1;
      move_q <= 1'h0;
    end else if (start) begin
      pos_q <= 2'h0;
      move_q <= 1'h1;
      tgt_q <= close_cmd_pulse;
      cnt_q <= travel_cyc;
    end else if (move_q && cnt_q == 8'h0) begin
      pos_q <= tgt_q ? 2'h2 : 2'h1;
      move_q <= 1'h0;
    end else if (move_q) begin
      cnt_q <= cnt_q - 8'h1;
    end
  end
  // A shorted contact pair shows both positions together.
  assign closed_position_in = pos_q[1] | fault_both;
  assign open_position_in = pos_q[0] | fault_both;
endmodule // sgc_switch_model

// [tb_switchgear_cmd_gating_status.sv]
// Purpose: Self-checking bench for command gating and position status.
// Assumes: Counts shortened through the design parameters.
// Notes: Expected event and operation totals follow the move sequence.
`timescale 1ns/1ps
module tb_switchgear_cmd_gating_status;
  localparam int unsigned OPC = 20;
  localparam int unsigned MINP = 10;
  localparam logic [31:0] PLS = 32'h1E;
  localparam logic [31:0] MXO = 32'h64;
  localparam logic [31:0] MXI = 32'h0F;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, travel_cyc = 8'h5;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, stuck = 1'h0;
  logic local_mode = 1'h0, remote_mode = 1'h0, fault_both = 1'h0;
  logic local_open_req = 1'h0, local_close_req = 1'h0, open_permit = 1'h1;
  logic close_permit = 1'h1, sync_check_ok = 1'h1, operation_block = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, closed_position_in, open_position_in, open_cmd_pulse;
  logic close_cmd_pulse, oper_pulse, closed_out, opened_out, status_event;
  logic cmd_timeout, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] integer_position_status, remote_position_status;
  int mismatches = 0;
  int cmp_count = 0;
  int ev_n = 0;
  sgc_ctrl #(.OPER_CYC(OPC), .MIN_PULSE_CYC(MINP), .PULSE_RST(PLS),
    .MAXOP_RST(MXO), .MAXINT_RST(MXI)) i_sgc_ctrl (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .local_mode,
    .remote_mode, .local_open_req, .local_close_req, .open_permit,
    .close_permit, .sync_check_ok, .operation_block, .closed_position_in,
    .open_position_in, .open_cmd_pulse, .close_cmd_pulse, .oper_pulse,
    .closed_out, .opened_out, .integer_position_status,
    .remote_position_status, .status_event, .cmd_timeout, .irq);
  sgc_switch_model i_sgc_switch_model (.aclk, .aresetn, .open_cmd_pulse,
    .close_cmd_pulse, .stuck, .fault_both, .travel_cyc, .closed_position_in,
    .open_position_in);
  // Free-running 200 MHz clock.
  initial forever #2.5 aclk = ~aclk;
  // Event tally, compared against the number of status changes made.
  always @(posedge aclk) if (aresetn && status_event === 1'h1) ev_n++;
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo();
    mismatches++;
    $display("[ERR] %0t: a wait ran out", $time);
    end_sim();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (n > 50) tmo();
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n > 50) tmo();
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  // Width of the next command pulse, or 0 when none starts in 6 cycles.
  task automatic pulse(input logic cl, output int w);
    w = 0;
    for (int n = 0; n < 6 && w == 0; n++) begin
      @(posedge aclk);
      if ((cl ? close_cmd_pulse : open_cmd_pulse) === 1'h1) w = 1;
    end
    while (w > 0 && (cl ? close_cmd_pulse : open_cmd_pulse) === 1'h1) begin
      @(posedge aclk);
      w++;
      if (w > 200) tmo();
    end
    if (w > 0) w--;
  endtask
  task automatic loc(input logic cl, output int w);
    if (cl) local_close_req <= 1'h1;
    else local_open_req <= 1'h1;
    @(posedge aclk);
    local_close_req <= 1'h0;
    local_open_req <= 1'h0;
    pulse(cl, w);
  endtask
  initial begin
    int w, n;
    logic [31:0] d;
    logic [1:0] r;
    cyc(4);
    aresetn <= 1'h1;
    cyc(4);
    chk({integer_position_status, opened_out, closed_out}, 32'h6);
    rchk(sgc_pkg::REG_CTRL, 32'h3);
    rchk(sgc_pkg::REG_PULSE, PLS);
    rchk(sgc_pkg::REG_MAXOP, MXO);
    rchk(sgc_pkg::REG_MAXINT, MXI);
    rd(8'h24, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(sgc_pkg::RESP_SLVERR));
    wr(8'h24, 32'h0, r);
    chk(r, sgc_pkg::RESP_SLVERR);
    fault_both <= 1'h1;
    cyc(4);
    chk({integer_position_status, remote_position_status}, 32'hF);
    fault_both <= 1'h0;
    local_mode <= 1'h1;
    sync_check_ok <= 1'h1;
    cyc(25);
    loc(1'h1, w);
    chk(32'(w >= MINP && w < PLS), 32'h1);
    cyc(3);
    chk({integer_position_status, closed_out}, 32'h5);
    // Each refused case leaves exactly one gating condition false.
    for (int i = 0; i < 6; i++) begin
      sync_check_ok <= (i != 0);
      close_permit <= (i != 1);
      open_permit <= (i != 2);
      operation_block <= (i == 3 || i == 5);
      local_mode <= (i != 4);
      cyc(1);
      loc(i != 2 && i != 5, w);
      chk(w, 32'h0);
    end
    close_permit <= 1'h1;
    open_permit <= 1'h1;
    operation_block <= 1'h0;
    sync_check_ok <= 1'h0;
    cyc(1);
    loc(1'h0, w);
    chk(32'(w > 0), 32'h1);
    rchk(sgc_pkg::REG_IRQ_STAT, 32'hB);
    chk(irq, 32'h0);
    sync_check_ok <= 1'h1;
    local_mode <= 1'h0;
    remote_mode <= 1'h1;
    cyc(20);
    wr(sgc_pkg::REG_CMD, 32'h2, r);
    pulse(1'h1, w);
    chk(32'(w > 0), 32'h1);
    local_mode <= 1'h1;
    remote_mode <= 1'h0;
    cyc(20);
    wr(sgc_pkg::REG_CMD, 32'h1, r);
    pulse(1'h0, w);
    chk(w, 32'h0);
    travel_cyc <= 8'h28;
    loc(1'h0, w);
    chk(w, PLS);
    chk(integer_position_status, 32'(sgc_pkg::ST_INTER));
    cyc(30);
    chk({integer_position_status, cmd_timeout}, 32'h2);
    chk(ev_n, 32'h8);
    wr(sgc_pkg::REG_IRQ_STAT, 32'hF, r);
    wr(sgc_pkg::REG_IRQ_MASK, 32'h4, r);
    stuck <= 1'h1;
    loc(1'h1, w);
    chk(w, PLS);
    n = 0;
    while (cmd_timeout !== 1'h1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 200) tmo();
    chk(32'(n + 3 >= MXO - PLS && n <= MXO - PLS + 3), 32'h1);
    cyc(3);
    chk(irq, 32'h1);
    wr(sgc_pkg::REG_IRQ_STAT, 32'h4, r);
    cyc(2);
    chk(irq, 32'h0);
    rchk(sgc_pkg::REG_OPCNT, 32'h6);
    wr(sgc_pkg::REG_CTRL, 32'h7, r);
    rchk(sgc_pkg::REG_OPCNT, 32'h0);
    end_sim();
  end
endmodule // tb_switchgear_cmd_gating_status
